// ### core/scc_ctrl.sv
// shared converter core control registers and interrupt routing
`timescale 1ns/100ps
`default_nettype none
`include "scc_defines.svh"
////////////////////////////////////////////////////////////////////////
// Contract
// - resolution field selects 12/10/8/6 bits
// - reference ready raises common irq when enabled
// - reference error raises common irq when enabled
// - early mode follows early status flag
// - otherwise channel irq on result ready
// - lead code selects 1 to 8 cycles
// - core period is twice divider code, code 0 same as code 1
module scc_ctrl #(
  parameter int NCH = 22
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic HSEL,
  input wire logic [11:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic REF_READY,
  input wire logic REF_ERROR,
  input wire logic [NCH-1:0] EARLY_STATUS_FLAG,
  input wire logic [NCH-1:0] CHANNEL_RESULT_READY,
  output logic [NCH-1:0] CHANNEL_IRQ,
  output logic COMMON_IRQ,
  output logic IRQ,
  output var scc_pkg::scc_res_e SHARED_CORE_RESOLUTION,
  output logic [2:0] SHARED_EARLY_IRQ_LEAD,
  output logic [3:0] EARLY_LEAD_CYCLES,
  output logic CORE_CLK,
  output logic CORE_TICK
);
  import scc_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // bus address phase capture
  scc_req_s req_r;
  logic [15:0] ctrl1h_r;
  logic [15:0] ctrl2l_r;
  logic [`SCC_ST_W-1:0] stat_r;
  logic [`SCC_ST_W-1:0] ien_r;
  logic [`SCC_ST_W-1:0] stat_nxt;
  logic [`SCC_ST_W-1:0] clr_w;
  logic [`SCC_ST_W-1:0] ev_w;
  logic [1:0] rdy_s_r;
  logic [1:0] err_s_r;
  logic rdy_d_r;
  logic err_d_r;
  logic [NCH-1:0] early_s1_r;
  logic [NCH-1:0] early_s2_r;
  logic [NCH-1:0] done_s1_r;
  logic [NCH-1:0] done_s2_r;
  logic [NCH-1:0] done_d_r;
  logic [NCH-1:0] chirq_nxt;
  logic addr_ph;
  logic wr_ph;
  logic wr_c1;
  logic wr_c2;
  logic wr_clr;
  logic wr_ien;
  logic [31:0] rd_w;
  logic rd_ph;
  logic rdy_ev;
  logic err_ev;
  logic early_en;
  logic common_nxt;
  // single-cycle data phase: slave never stalls, always okay
  assign addr_ph = HSEL & HTRANS[1] & HREADY;
  assign wr_ph = req_r.sel & req_r.write;
  assign wr_c1 = wr_ph & (req_r.addr == `SCC_OFS_CTRL1H);
  assign wr_c2 = wr_ph & (req_r.addr == `SCC_OFS_CTRL2L);
  assign wr_clr = wr_ph & (req_r.addr == `SCC_OFS_CLR);
  assign wr_ien = wr_ph & (req_r.addr == `SCC_OFS_IEN);
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      req_r <= '0;
    else
      req_r <= '{sel: addr_ph, write: HWRITE, addr: HADDR};
  end
  ////////////////////////////////////////////////////////////////////////
  // control registers; reserved bits are masked so they hold zero
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ctrl1h_r <= `SCC_CTRL1H_RESET;
      ctrl2l_r <= `SCC_CTRL2L_RESET;
      ien_r <= '0;
    end
    else
    begin
      if (wr_c1)
        ctrl1h_r <= HWDATA[15:0] & `SCC_CTRL1H_WMASK;
      // bit 7 and reserved bits never stored
      if (wr_c2)
        ctrl2l_r <= HWDATA[15:0] & `SCC_CTRL2L_WMASK;
      if (wr_ien)
        ien_r <= HWDATA[`SCC_ST_W-1:0];
    end
  end
  // resolution code straight to the core
  assign SHARED_CORE_RESOLUTION = scc_res_e'(ctrl1h_r[`SCC_RES_HI:`SCC_RES_LO]);
  // field placement in the interrupt and clock register
  assign SHARED_EARLY_IRQ_LEAD = ctrl2l_r[`SCC_LEAD_HI:`SCC_LEAD_LO];
  // code n fires n+1 core cycles early
  assign EARLY_LEAD_CYCLES = {1'b0, SHARED_EARLY_IRQ_LEAD} + 4'h1;
  assign early_en = ctrl2l_r[`SCC_BIT_EARLY];
  // read mux on the address phase; unmapped reads return zero
  assign rd_ph = addr_ph & ~HWRITE;
  assign rd_w = (HADDR == `SCC_OFS_CTRL1H) ? {16'h0000, ctrl1h_r} :
                (HADDR == `SCC_OFS_CTRL2L) ? {16'h0000, ctrl2l_r} :
                (HADDR == `SCC_OFS_STAT) ? {30'h00000000, stat_r} :
                (HADDR == `SCC_OFS_IEN) ? {30'h00000000, ien_r} : 32'h00000000;
  // registered at the address phase so data stands through the data phase with no wait state
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      HRDATA <= '0;
    else if (rd_ph)
      HRDATA <= rd_w;
  end
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      rdy_s_r <= '0;
      err_s_r <= '0;
      rdy_d_r <= 1'b0;
      err_d_r <= 1'b0;
      early_s1_r <= '0;
      early_s2_r <= '0;
      done_s1_r <= '0;
      done_s2_r <= '0;
      done_d_r <= '0;
    end
    else
    begin
      rdy_s_r <= {rdy_s_r[0], REF_READY};
      err_s_r <= {err_s_r[0], REF_ERROR};
      rdy_d_r <= rdy_s_r[1];
      err_d_r <= err_s_r[1];
      early_s1_r <= EARLY_STATUS_FLAG;
      early_s2_r <= early_s1_r;
      done_s1_r <= CHANNEL_RESULT_READY;
      done_s2_r <= done_s1_r;
      done_d_r <= done_s2_r;
    end
  end
  assign rdy_ev = rdy_s_r[1] & ~rdy_d_r;
  assign err_ev = err_s_r[1] & ~err_d_r;
  ////////////////////////////////////////////////////////////////////////
  // sticky status: a set in the clear cycle wins
  assign ev_w = {err_ev, rdy_ev};
  assign clr_w = wr_clr ? HWDATA[`SCC_ST_W-1:0] : '0;
  assign stat_nxt = (stat_r & ~clr_w) | ev_w;
  // each sticky status bit (next value) gated by its enable, then ORed
  assign common_nxt = (stat_nxt[`SCC_ST_RDY] & ctrl2l_r[`SCC_BIT_RDY_IE]) |
                      (stat_nxt[`SCC_ST_ERR] & ctrl2l_r[`SCC_BIT_ERR_IE]);
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      stat_r <= '0;
      COMMON_IRQ <= 1'b0;
    end
    else
    begin
      stat_r <= stat_nxt;
      COMMON_IRQ <= common_nxt;
    end
  end
  // summary line: enabled status bits
  assign IRQ = |(stat_r & ien_r);
  ////////////////////////////////////////////////////////////////////////
  // per-channel request source chosen by early mode
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      // early flag level or result-ready rising edge
      assign chirq_nxt[g] = early_en ? early_s2_r[g] : (done_s2_r[g] & ~done_d_r[g]);
    end
  endgenerate
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      CHANNEL_IRQ <= '0;
    else
      CHANNEL_IRQ <= chirq_nxt;
  end
  ////////////////////////////////////////////////////////////////////////
  // core clock divider
  scc_clkdiv #(.DIV_W(7)) u_div (
    .CLK(CLK),
    .ARST_N(ARST_N),
    .DIV_CODE(ctrl2l_r[`SCC_DIV_HI:`SCC_DIV_LO]),
    .CORE_TICK(CORE_TICK),
    .CORE_CLK(CORE_CLK)
  );
  ////////////////////////////////////////////////////////////////////////
  // checks
  a_rdy_gate: assert property (@(posedge CLK) disable iff (!ARST_N)
    rdy_ev && !ctrl2l_r[`SCC_BIT_ERR_IE] && !stat_r[`SCC_ST_ERR]
    |=> COMMON_IRQ == $past(ctrl2l_r[`SCC_BIT_RDY_IE]))
    else $error("ready event gating wrong");
  a_err_gate: assert property (@(posedge CLK) disable iff (!ARST_N)
    err_ev && ctrl2l_r[`SCC_BIT_ERR_IE] |=> COMMON_IRQ)
    else $error("error event lost");
  a_common_or: assert property (@(posedge CLK) disable iff (!ARST_N)
    COMMON_IRQ |-> $past(ctrl2l_r[`SCC_BIT_RDY_IE] | ctrl2l_r[`SCC_BIT_ERR_IE]))
    else $error("common irq without enable");
  a_early_follow: assert property (@(posedge CLK) disable iff (!ARST_N)
    early_en |=> CHANNEL_IRQ == $past(early_s2_r))
    else $error("early mode not followed");
  a_done_only: assert property (@(posedge CLK) disable iff (!ARST_N)
    !early_en |=> (CHANNEL_IRQ & ~$past(done_s2_r)) == '0)
    else $error("channel irq without result");
  a_bit7_zero: assert property (@(posedge CLK) disable iff (!ARST_N)
    !ctrl2l_r[7] && !ctrl2l_r[13] && !ctrl2l_r[11])
    else $error("unimplemented bit stored");
  a_res_field: assert property (@(posedge CLK) disable iff (!ARST_N)
    wr_c1 |=> SHARED_CORE_RESOLUTION == scc_res_e'($past(HWDATA[`SCC_RES_HI:`SCC_RES_LO])))
    else $error("resolution not written");
  a_lead_range: assert property (@(posedge CLK) disable iff (!ARST_N)
    EARLY_LEAD_CYCLES >= 4'h1 && EARLY_LEAD_CYCLES <= 4'h8)
    else $error("lead out of range");
  c_ready_irq: cover property (@(posedge CLK) disable iff (!ARST_N) rdy_ev ##1 COMMON_IRQ);
  c_err_irq: cover property (@(posedge CLK) disable iff (!ARST_N) err_ev ##1 COMMON_IRQ);
  c_early: cover property (@(posedge CLK) disable iff (!ARST_N) early_en && |CHANNEL_IRQ);
  c_done: cover property (@(posedge CLK) disable iff (!ARST_N) !early_en && |CHANNEL_IRQ);
endmodule : scc_ctrl
`default_nettype wire

// ### core/scc_defines.svh
// constants for the shared converter core control block
`ifndef SCC_DEFINES_SVH
`define SCC_DEFINES_SVH
`define SCC_OFS_CTRL1H 12'h000
`define SCC_OFS_CTRL2L 12'h004
`define SCC_OFS_STAT 12'h008
`define SCC_OFS_CLR 12'h00C
`define SCC_OFS_IEN 12'h010
`define SCC_RES_LO 5
`define SCC_RES_HI 6
`define SCC_RSV1_MASK 16'h001F
`define SCC_CTRL1H_RESET 16'h0060
`define SCC_CTRL1H_WMASK 16'h0060
`define SCC_CTRL2L_WMASK 16'hD77F
`define SCC_CTRL2L_RESET 16'h0000
`define SCC_BIT_RDY_IE 15
`define SCC_BIT_ERR_IE 14
`define SCC_BIT_EARLY 12
`define SCC_LEAD_LO 8
`define SCC_LEAD_HI 10
`define SCC_DIV_LO 0
`define SCC_DIV_HI 6
`define SCC_ST_RDY 0
`define SCC_ST_ERR 1
`define SCC_ST_W 2
`define SCC_DIV_MIN 7'h01
`endif

// ### core/scc_pkg.sv
// types shared by the shared converter core control block
package scc_pkg;
  typedef struct packed {
    logic sel;
    logic write;
    logic [11:0] addr;
  } scc_req_s;
  typedef enum logic [1:0] {
    SCC_RES_6,
    SCC_RES_8,
    SCC_RES_10,
    SCC_RES_12
  } scc_res_e;
endpackage : scc_pkg

// ### core/scc_clkdiv.sv
// core clock divider: half period of code source clocks, code 0 counted as 1
`timescale 1ns/100ps
`default_nettype none
`include "scc_defines.svh"
module scc_clkdiv #(
  parameter int DIV_W = 7
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic [DIV_W-1:0] DIV_CODE,
  output logic CORE_TICK,
  output logic CORE_CLK
);
  logic [DIV_W-1:0] cnt_r;
  logic [DIV_W-1:0] half;
  logic wrap;
  // codes 0 and 1 both give two source clocks
  assign half = (DIV_CODE < `SCC_DIV_MIN) ? `SCC_DIV_MIN : DIV_CODE;
  assign wrap = (cnt_r >= half - `SCC_DIV_MIN);
  assign CORE_TICK = wrap & CORE_CLK;
  // counter restarts at each half period
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      cnt_r <= '0;
      CORE_CLK <= 1'b0;
    end
    else if (wrap)
    begin
      cnt_r <= '0;
      CORE_CLK <= ~CORE_CLK;
    end
    else
      cnt_r <= cnt_r + 1'b1;
  end
  // code two holds the high half for two source clocks
  a_div_period: assert property (@(posedge CLK) disable iff (!ARST_N)
    $rose(CORE_CLK) && DIV_CODE == 7'h02 && $stable(DIV_CODE) |=> CORE_CLK ##1 !CORE_CLK)
    else $error("core clock half period wrong");
endmodule : scc_clkdiv
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench for the shared converter core control block
`timescale 1ns/100ps
`default_nettype none
`include "scc_defines.svh"
module tb_top;
  import scc_pkg::*;
  logic CLK, ARST_N, HSEL, HWRITE, HREADYOUT, HRESP, REF_READY, REF_ERROR, COMMON_IRQ, IRQ, CORE_CLK, CORE_TICK;
  logic [11:0] HADDR;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE, SHARED_EARLY_IRQ_LEAD;
  logic [3:0] EARLY_LEAD_CYCLES;
  logic [31:0] HWDATA, HRDATA, r;
  logic [21:0] EARLY_STATUS_FLAG, CHANNEL_RESULT_READY, CHANNEL_IRQ;
  scc_res_e SHARED_CORE_RESOLUTION;
  wire [24:0] mon = {CORE_CLK, COMMON_IRQ, IRQ, CHANNEL_IRQ};
  int miscompares = 0, compares = 0, n;
  scc_res_e res_tab [4] = '{SCC_RES_6, SCC_RES_8, SCC_RES_10, SCC_RES_12};
  scc_ctrl u_dut (.CLK(CLK), .ARST_N(ARST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .REF_READY(REF_READY), .REF_ERROR(REF_ERROR), .EARLY_STATUS_FLAG(EARLY_STATUS_FLAG),
    .CHANNEL_RESULT_READY(CHANNEL_RESULT_READY), .CHANNEL_IRQ(CHANNEL_IRQ), .COMMON_IRQ(COMMON_IRQ), .IRQ(IRQ),
    .SHARED_CORE_RESOLUTION(SHARED_CORE_RESOLUTION), .SHARED_EARLY_IRQ_LEAD(SHARED_EARLY_IRQ_LEAD),
    .EARLY_LEAD_CYCLES(EARLY_LEAD_CYCLES), .CORE_CLK(CORE_CLK), .CORE_TICK(CORE_TICK));
  ////////////////////////////////////////////////////////////////////////
  // 20 MHz clock
  initial
  begin
    CLK = 0;
    forever #25 CLK = ~CLK;
  end
  task give_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  ////////////////////////////////////////////////////////////////////////
  // bus cycles; every wait is bounded so a stuck slave ends the run
  task wait_rdy;
    @(posedge CLK);
    for (int k = 0; HREADYOUT !== 1'b1; k++)
    begin
      if (k > 16)
      begin
        miscompares++;
        give_verdict();
      end
      @(posedge CLK);
    end
  endtask : wait_rdy
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= a;
    HWRITE <= w;
    HSIZE <= 3'h2;
    wait_rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    wait_rdy();
    // read data stands in the data phase and is taken at its closing edge
    r = HRDATA;
    // one idle edge so register outputs have settled for the caller
    @(posedge CLK);
  endtask : bus
  task rd(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(r, exp);
  endtask : rd
  // cycles until mon[i] next rises, bounded
  task automatic rise(input int i, output int c);
    logic p;
    c = 0;
    p = mon[i];
    repeat (300)
    begin
      @(posedge CLK);
      c++;
      if (!p && mon[i] === 1'b1)
        return;
      p = mon[i];
    end
    miscompares++;
    give_verdict();
  endtask : rise
  task idle(input int c);
    repeat (c) @(posedge CLK);
  endtask : idle
  ////////////////////////////////////////////////////////////////////////
  task t_regs;
    rd(`SCC_OFS_CTRL1H, 32'h60);
    rd(`SCC_OFS_CTRL2L, 32'h0);
    rd(12'h0F0, 32'h0);
    // each resolution code written, decoded and read back
    for (int c = 0; c < 4; c++)
    begin
      @(posedge CLK);
      bus(1'b1, `SCC_OFS_CTRL1H, 32'(c << 5));
      chk(SHARED_CORE_RESOLUTION, res_tab[c]);
      rd(`SCC_OFS_CTRL1H, 32'(c << 5));
    end
    // bit 7 is written as one and reads back zero; bits 13 and 11 are only ever written as zero
    @(posedge CLK);
    bus(1'b1, `SCC_OFS_CTRL2L, 32'hD7FF);
    rd(`SCC_OFS_CTRL2L, 32'hD77F);
    for (int l = 0; l < 8; l++)
    begin
      @(posedge CLK);
      bus(1'b1, `SCC_OFS_CTRL2L, 32'(l << 8));
      chk(SHARED_EARLY_IRQ_LEAD, l);
      chk(EARLY_LEAD_CYCLES, l + 1);
    end
  endtask : t_regs
  task automatic t_div;
    int codes [5] = '{0, 1, 2, 3, 5};
    foreach (codes[i])
    begin
      @(posedge CLK);
      bus(1'b1, `SCC_OFS_CTRL2L, 32'(codes[i]));
      rise(24, n);
      rise(24, n);
      chk(n, codes[i] < 2 ? 2 : 2 * codes[i]);
    end
  endtask : t_div
  task t_common;
    @(posedge CLK);
    bus(1'b1, `SCC_OFS_CTRL2L, 32'h0);
    REF_READY <= 1'b1;
    REF_ERROR <= 1'b1;
    idle(8);
    chk(COMMON_IRQ, 0);
    rd(`SCC_OFS_STAT, 32'h3);
    bus(1'b1, `SCC_OFS_IEN, 32'h1);
    chk(IRQ, 1);
    bus(1'b1, `SCC_OFS_CLR, 32'h3);
    REF_READY <= 1'b0;
    REF_ERROR <= 1'b0;
    idle(1);
    chk(IRQ, 0);
    bus(1'b1, `SCC_OFS_CTRL2L, 32'h8000);
    REF_READY <= 1'b1;
    rise(23, n);
    chk(IRQ, 1);
    bus(1'b1, `SCC_OFS_CTRL2L, 32'h4000);
    idle(1);
    chk(COMMON_IRQ, 0);
    bus(1'b1, `SCC_OFS_CLR, 32'h3);
    REF_ERROR <= 1'b1;
    rise(23, n);
    chk(IRQ, 0);
    rd(`SCC_OFS_STAT, 32'h2);
    bus(1'b1, `SCC_OFS_CLR, 32'h2);
    idle(1);
    chk(COMMON_IRQ, 0);
  endtask : t_common
  task t_chan;
    @(posedge CLK);
    bus(1'b1, `SCC_OFS_CTRL2L, 32'h0);
    EARLY_STATUS_FLAG[5] <= 1'b1;
    idle(8);
    chk(CHANNEL_IRQ, 0);
    CHANNEL_RESULT_READY[3] <= 1'b1;
    rise(3, n);
    idle(1);
    chk(CHANNEL_IRQ, 0);
    bus(1'b1, `SCC_OFS_CTRL2L, 32'h1000);
    idle(6);
    chk(CHANNEL_IRQ, 22'h20);
    EARLY_STATUS_FLAG[5] <= 1'b0;
    idle(6);
    chk(CHANNEL_IRQ, 0);
  endtask : t_chan
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {ARST_N, HSEL, HWRITE, REF_READY, REF_ERROR, HADDR, HTRANS, HSIZE, HWDATA} = '0;
    EARLY_STATUS_FLAG = '0;
    CHANNEL_RESULT_READY = '0;
    repeat (2) @(posedge CLK);
    ARST_N <= 1'b1;
    // t_common and t_chan rewrite their configuration between driven events
    t_regs();
    t_div();
    t_common();
    t_chan();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
